// File: inc/rsw_pkg.sv
// constants, register map and state type of the reset and sleep sequencer
// assumes one 250 MHz clock and an AXI4-Lite register bus with 32-bit data
package rsw_pkg;

	// clock rate and oscillator start-up delay
	localparam int CLK_MHZ         = 250;
	localparam int STARTUP_TIME_US = 18000;
	localparam int STARTUP_CYCLES  = STARTUP_TIME_US * CLK_MHZ;
	localparam int TMR_W           = 23;

	// program counter width and its reset value (top of program memory)
	localparam int            PC_W     = 10;
	localparam logic [PC_W-1:0] PC_RESET = 10'h3FF;

	// register byte offsets
	localparam int              ADDR_W      = 8;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BANK    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OPTION  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_WMASK   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IFLAG   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IMASK   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DIR5    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_DIR6    = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_DIR7    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_SEQ     = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_PC      = 8'h2C;

	// status flags: time-out and power-down bits, power-on cleared field
	localparam int         ST_T_BIT     = 4;
	localparam int         ST_P_BIT     = 3;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] ST_POR_MASK  = 8'h60;
	localparam logic [7:0] ST_WR_MASK   = 8'hE7;
	localparam logic [7:0] BANK_POR_MASK = 8'hC0;

	// option register: all ones, interrupt flag bit kept except at power-on
	localparam int         OPT_KEEP_BIT = 6;
	localparam logic [7:0] OPT_RESET    = 8'hFF;
	localparam logic [7:0] OPT_POR      = 8'hBF;

	// wake mask, port direction, sleep/watchdog control, interrupt bits
	localparam logic [7:0] WMASK_RESET  = 8'hFF;
	localparam logic [7:0] DIR_RESET    = 8'hFF;
	localparam logic [7:0] CTRL_RESET   = 8'h31;
	localparam logic [7:0] CTRL_WR_MASK = 8'h79;
	localparam int         CTRL_WUE_BIT  = 0;
	localparam int         CTRL_OSCILLATOR_RUN_BIT_BIT = 4;
	localparam int         CTRL_WDTE_BIT = 5;
	localparam logic [7:0] INT_CLR_MASK = 8'h09;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_RUN,
		ST_SLEEP1,
		ST_SLEEP2,
		ST_WAKE
	} rsw_state_t;

endpackage

// File: core/rsw_startup_timer.sv
// oscillator start-up timer: counts down a fixed delay after each start
// assumes start is a level or pulse in the aclk domain
`timescale 1ns/1ps
module rsw_startup_timer #(
	parameter int CYCLES = rsw_pkg::STARTUP_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	output logic      done
);

	localparam logic [rsw_pkg::TMR_W-1:0] LOAD =
		rsw_pkg::TMR_W'(CYCLES - 1);

	logic [rsw_pkg::TMR_W-1:0] cnt_q;

	////////////////////////////////////////////////////////////////////////
	// a held start keeps reloading, so the delay runs from its last cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= LOAD;
		end else if (start) begin
			cnt_q <= LOAD;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done = (cnt_q == '0);

endmodule

// File: core/rsw_seq.sv
// reset and sleep/wake-up sequencer with AXI4-Lite control registers
// assumes pins are sampled on aclk and the core obeys halt and reset
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - reset comes from power-on, low reset pin, or enabled watchdog time-out
// - reset is held one start-up timer period after its last source cycle
// - every reset loads the program counter with all ones
// - power-on alone clears status bits 5-6 and bank bits 7-6
// - reset makes every port pin an input
// - reset clears the watchdog and prescaler counters
// - reset sets option register to ones, bit 6 left alone except power-on clears it
// - reset sets the port wake mask to all ones
// - reset clears control bits 3, 6 and sets bits 0, 4, 5
// - reset clears bits 0, 3 of interrupt flag and mask
// - the sleep instruction enters sleep 1
// - sleep entry clears an enabled watchdog, which keeps running
// - sleep 1 wakes only through reset pin or watchdog, via reset
// - time-out and power-down flags record the reset or wake cause
// - clearing the oscillator-run bit enters sleep 2, oscillator stopped
// - enabled wake pin low in sleep 2 resumes without reset
// - after a pin wake the watchdog is enabled regardless of fuse
// - in sleep 2 watchdog time-out or reset pin forces full reset
// - hardware sets the oscillator-run bit on a pin wake
// - a wake mask bit of 0 enables, 1 disables its pin
// - every wake starts the start-up timer and halts execution
module rsw_seq #(
	parameter int STARTUP_CYCLES = rsw_pkg::STARTUP_CYCLES
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [rsw_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [rsw_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire logic                      power_on_det,
	input  wire logic                      ext_reset_n,
	input  wire logic                      wdt_timeout,
	input  wire logic                      watchdog_config_fuse,
	input  wire logic                      enter_sleep_op,
	input  wire logic [7:0]                port6_wake_pins,
	input  wire logic [1:0]                port7_wake_pins,
	output logic                           core_reset_q,
	output logic                           core_halt_q,
	output logic                           osc_enable_q,
	output logic                           wdt_enable_q,
	output logic                           wdt_clear_q,
	output logic                           prescaler_clear_q,
	output logic [rsw_pkg::PC_W-1:0]       program_counter_q,
	output logic [7:0]                     option_control_reg_q,
	output logic [7:0]                     port5_dir_q,
	output logic [7:0]                     port6_dir_q,
	output logic [7:0]                     port7_dir_q
);

	rsw_pkg::rsw_state_t state_q;
	rsw_pkg::rsw_state_t state_d;
	logic [1:0]  ext_rst_sync_q;
	logic [9:0]  wake_meta_q;
	logic [9:0]  wake_sync_q;
	logic        por_flag_q;
	logic        wdt_force_q;
	logic [7:0]  status_flag_reg_q;
	logic [7:0]  bank_select_reg_q;
	logic [7:0]  port_wake_mask_reg_q;
	logic [7:0]  sleep_watchdog_ctrl_reg_q;
	logic [7:0]  interrupt_flag_reg_q;
	logic [7:0]  interrupt_mask_reg_q;
	logic [rsw_pkg::ADDR_W-1:0] awaddr_q;
	logic [7:0]  wdata_q;
	logic        wstrb0_q;
	logic        por_src;
	logic        wdt_src;
	logic        rst_src;
	logic        wdt_active;
	logic        wake_hit;
	logic        sleep_entry;
	logic        tmr_start;
	logic        tmr_done;
	logic        do_write;
	logic        oscillator_run_bit_clear_wr;
	logic [9:0]  wake_en;
	logic [7:0]  rd_data;
	logic        rd_err;

	////////////////////////////////////////////////////////////////////////
	// the first stage is read only by the second, never by wake logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_rst_sync_q <= 2'h3;
			wake_meta_q    <= 10'h3FF;
			wake_sync_q    <= 10'h3FF;
		end else begin
			ext_rst_sync_q <= {ext_rst_sync_q[0], ext_reset_n};
			wake_meta_q    <= {port7_wake_pins, port6_wake_pins};
			wake_sync_q    <= wake_meta_q;
		end
	end

	// bus reset counts as power-on for the first cycle after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_q <= 1'b1;
		end else begin
			por_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset sources and wake detection
	assign wdt_active = wdt_force_q |
		(!watchdog_config_fuse &
		sleep_watchdog_ctrl_reg_q[rsw_pkg::CTRL_WDTE_BIT]);
	assign por_src = power_on_det | por_flag_q;
	assign wdt_src = wdt_timeout & wdt_active;
	assign rst_src = por_src | !ext_rst_sync_q[1] | wdt_src;

	// per-pin enable: a low wake mask bit lets a port 6 pin wake the device, a low control bit 0 both port 7 pins
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_wake
			if (gi < 8) begin : g_p6
				assign wake_en[gi] = !port_wake_mask_reg_q[gi];
			end else begin : g_p7
				assign wake_en[gi] =
					!sleep_watchdog_ctrl_reg_q[rsw_pkg::CTRL_WUE_BIT];
			end
		end
	endgenerate
	assign wake_hit = |(wake_en & ~wake_sync_q);

	assign sleep_entry = (state_q == rsw_pkg::ST_RUN) && enter_sleep_op &&
		!rst_src;
	assign oscillator_run_bit_clear_wr = do_write && wstrb0_q &&
		(awaddr_q == rsw_pkg::OFS_CTRL) &&
		!wdata_q[rsw_pkg::CTRL_OSCILLATOR_RUN_BIT_BIT];
	assign tmr_start = rst_src ||
		((state_q == rsw_pkg::ST_SLEEP2) && wake_hit);

	rsw_startup_timer #(
		.CYCLES (STARTUP_CYCLES)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (tmr_start),
		.done    (tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: any reset source overrides every state
	always_comb begin
		state_d = state_q;
		if (rst_src) begin
			state_d = rsw_pkg::ST_RESET;
		end else begin
			unique case (state_q)
				rsw_pkg::ST_RESET: begin
					if (tmr_done) state_d = rsw_pkg::ST_RUN;
				end
				rsw_pkg::ST_RUN: begin
					if (enter_sleep_op) begin
						state_d = rsw_pkg::ST_SLEEP1;
					end else if (oscillator_run_bit_clear_wr) begin
						state_d = rsw_pkg::ST_SLEEP2;
					end
				end
				rsw_pkg::ST_SLEEP1: state_d = rsw_pkg::ST_SLEEP1;
				rsw_pkg::ST_SLEEP2: begin
					if (wake_hit) state_d = rsw_pkg::ST_WAKE;
				end
				rsw_pkg::ST_WAKE: begin
					if (tmr_done) state_d = rsw_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= rsw_pkg::ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// core controls follow the next state so they leave with no lag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset_q      <= 1'b1;
			core_halt_q       <= 1'b1;
			osc_enable_q      <= 1'b1;
			program_counter_q <= rsw_pkg::PC_RESET;
		end else begin
			core_reset_q <= (state_d == rsw_pkg::ST_RESET);
			core_halt_q  <= (state_d != rsw_pkg::ST_RUN);
			osc_enable_q <= (state_d != rsw_pkg::ST_SLEEP2);
			if (rst_src) begin
				program_counter_q <= rsw_pkg::PC_RESET;
			end
		end
	end

	// watchdog and prescaler clears; the watchdog keeps running in sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_clear_q       <= 1'b1;
			prescaler_clear_q <= 1'b1;
			wdt_enable_q      <= 1'b0;
		end else begin
			wdt_clear_q       <= rst_src || (sleep_entry && wdt_active);
			prescaler_clear_q <= rst_src || (sleep_entry && wdt_active);
			wdt_enable_q      <= wdt_active;
		end
	end

	// a pin wake forces the watchdog on until software rewrites control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_force_q <= 1'b0;
		end else if (rst_src) begin
			wdt_force_q <= 1'b0;
		end else if ((state_q == rsw_pkg::ST_SLEEP2) && wake_hit) begin
			wdt_force_q <= 1'b1;
		end else if (do_write && wstrb0_q &&
			(awaddr_q == rsw_pkg::OFS_CTRL)) begin
			wdt_force_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags; time-out and power-down bits are hardware only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flag_reg_q <= rsw_pkg::STATUS_RESET;
		end else if (rst_src) begin
			if (por_src) begin
				status_flag_reg_q <= (status_flag_reg_q &
					~rsw_pkg::ST_POR_MASK) | rsw_pkg::STATUS_RESET;
			end else if (wdt_src) begin
				status_flag_reg_q[rsw_pkg::ST_T_BIT] <= 1'b0;
			end
		end else if (sleep_entry ||
			(oscillator_run_bit_clear_wr && (state_q == rsw_pkg::ST_RUN))) begin
			status_flag_reg_q[rsw_pkg::ST_T_BIT] <= 1'b1;
			status_flag_reg_q[rsw_pkg::ST_P_BIT] <= 1'b0;
		end else if (do_write && wstrb0_q &&
			(awaddr_q == rsw_pkg::OFS_STATUS)) begin
			status_flag_reg_q <= (wdata_q & rsw_pkg::ST_WR_MASK) |
				(status_flag_reg_q & ~rsw_pkg::ST_WR_MASK);
		end
	end

	// bank select: upper bits cleared by power-on only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_select_reg_q <= 8'h00;
		end else if (rst_src && por_src) begin
			bank_select_reg_q <= bank_select_reg_q &
				~rsw_pkg::BANK_POR_MASK;
		end else if (do_write && wstrb0_q &&
			(awaddr_q == rsw_pkg::OFS_BANK)) begin
			bank_select_reg_q <= wdata_q;
		end
	end

	// option register; bit 6 survives a reset other than power-on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			option_control_reg_q <= rsw_pkg::OPT_POR;
		end else if (rst_src && por_src) begin
			option_control_reg_q <= rsw_pkg::OPT_POR;
		end else if (rst_src) begin
			option_control_reg_q <= rsw_pkg::OPT_RESET;
			option_control_reg_q[rsw_pkg::OPT_KEEP_BIT] <=
				option_control_reg_q[rsw_pkg::OPT_KEEP_BIT];
		end else if (do_write && wstrb0_q &&
			(awaddr_q == rsw_pkg::OFS_OPTION)) begin
			option_control_reg_q <= wdata_q;
		end
	end

	// wake mask, port directions and interrupt registers
	always_ff @(posedge aclk) begin
		if (!aresetn || rst_src) begin
			port_wake_mask_reg_q <= rsw_pkg::WMASK_RESET;
			port5_dir_q          <= rsw_pkg::DIR_RESET;
			port6_dir_q          <= rsw_pkg::DIR_RESET;
			port7_dir_q          <= rsw_pkg::DIR_RESET;
			interrupt_flag_reg_q <= interrupt_flag_reg_q &
				~rsw_pkg::INT_CLR_MASK;
			interrupt_mask_reg_q <= interrupt_mask_reg_q &
				~rsw_pkg::INT_CLR_MASK;
		end else if (do_write && wstrb0_q) begin
			unique case (awaddr_q)
				rsw_pkg::OFS_WMASK: port_wake_mask_reg_q <= wdata_q;
				rsw_pkg::OFS_DIR5:  port5_dir_q          <= wdata_q;
				rsw_pkg::OFS_DIR6:  port6_dir_q          <= wdata_q;
				rsw_pkg::OFS_DIR7:  port7_dir_q          <= wdata_q;
				rsw_pkg::OFS_IFLAG: interrupt_flag_reg_q <= wdata_q;
				rsw_pkg::OFS_IMASK: interrupt_mask_reg_q <= wdata_q;
				default: ;
			endcase
		end
	end

	// control register; the wake set wins over a clearing write
	always_ff @(posedge aclk) begin
		if (!aresetn || rst_src) begin
			sleep_watchdog_ctrl_reg_q <= rsw_pkg::CTRL_RESET;
		end else if ((state_q == rsw_pkg::ST_SLEEP2) && wake_hit) begin
			sleep_watchdog_ctrl_reg_q[rsw_pkg::CTRL_OSCILLATOR_RUN_BIT_BIT] <= 1'b1;
		end else if (do_write && wstrb0_q &&
			(awaddr_q == rsw_pkg::OFS_CTRL)) begin
			sleep_watchdog_ctrl_reg_q <= wdata_q & rsw_pkg::CTRL_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write side: address and data latched in either order
	assign do_write = !awready && !wready && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= rsw_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q  <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				awready  <= 1'b0;
			end
			if (wvalid && wready) begin
				wdata_q  <= wdata[7:0];
				wstrb0_q <= wstrb[0];
				wready   <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= (awaddr_q > rsw_pkg::OFS_IMASK &&
					awaddr_q != rsw_pkg::OFS_DIR5 &&
					awaddr_q != rsw_pkg::OFS_DIR6 &&
					awaddr_q != rsw_pkg::OFS_DIR7) ||
					awaddr_q[1:0] != 2'h0 ?
					rsw_pkg::RESP_SLVERR : rsw_pkg::RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read decode; the sequencer word shows state and forced watchdog
	always_comb begin
		rd_data = 8'h00;
		rd_err  = 1'b0;
		unique case (araddr)
			rsw_pkg::OFS_STATUS: rd_data = status_flag_reg_q;
			rsw_pkg::OFS_BANK:   rd_data = bank_select_reg_q;
			rsw_pkg::OFS_OPTION: rd_data = option_control_reg_q;
			rsw_pkg::OFS_WMASK:  rd_data = port_wake_mask_reg_q;
			rsw_pkg::OFS_CTRL:   rd_data = sleep_watchdog_ctrl_reg_q;
			rsw_pkg::OFS_IFLAG:  rd_data = interrupt_flag_reg_q;
			rsw_pkg::OFS_IMASK:  rd_data = interrupt_mask_reg_q;
			rsw_pkg::OFS_DIR5:   rd_data = port5_dir_q;
			rsw_pkg::OFS_DIR6:   rd_data = port6_dir_q;
			rsw_pkg::OFS_DIR7:   rd_data = port7_dir_q;
			rsw_pkg::OFS_SEQ:    rd_data = {3'h0, wdt_active, wdt_force_q,
				state_q};
			rsw_pkg::OFS_PC:     rd_data = program_counter_q[7:0];
			default:             rd_err  = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= rsw_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h00_0000, rd_data};
			rresp   <= rd_err ? rsw_pkg::RESP_SLVERR : rsw_pkg::RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks on the sequencer
	release_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(core_reset_q) |-> $past(tmr_done) && !$past(rst_src))
		else $error("reset released before timer or with a source active");
	pc_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src |=> program_counter_q == rsw_pkg::PC_RESET && core_reset_q)
		else $error("program counter not all ones after reset");
	por_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src && por_src |=> (status_flag_reg_q & 8'h60) == 8'h00 &&
		(bank_select_reg_q & 8'hC0) == 8'h00)
		else $error("power-on did not clear status or bank bits");
	port_input_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src |=> (port5_dir_q & port6_dir_q & port7_dir_q) == 8'hFF)
		else $error("port left as output after reset");
	wdt_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src |=> wdt_clear_q && prescaler_clear_q)
		else $error("watchdog or prescaler not cleared on reset");
	option_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src && !por_src |=> option_control_reg_q ==
		(8'hBF | {1'b0, $past(option_control_reg_q[6]), 6'h00}))
		else $error("option register wrong after reset");
	ctrl_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src |=> sleep_watchdog_ctrl_reg_q == 8'h31 &&
		port_wake_mask_reg_q == 8'hFF && !wdt_force_q)
		else $error("control or wake mask wrong after reset");
	intr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rst_src |=> (interrupt_flag_reg_q & 8'h09) == 8'h00 &&
		(interrupt_mask_reg_q & 8'h09) == 8'h00)
		else $error("interrupt bits not cleared on reset");
	sleep_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_entry ##1 !rst_src |-> state_q == rsw_pkg::ST_SLEEP1 &&
		!status_flag_reg_q[3] ##1 core_halt_q)
		else $error("sleep instruction did not enter sleep 1");
	sleep_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == rsw_pkg::ST_SLEEP2 |-> !osc_enable_q)
		else $error("oscillator running in sleep 2");
	pin_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == rsw_pkg::ST_SLEEP2 && wake_hit && !rst_src |=>
		state_q == rsw_pkg::ST_WAKE && osc_enable_q && core_halt_q &&
		sleep_watchdog_ctrl_reg_q[4] && !core_reset_q ##1 wdt_enable_q)
		else $error("pin wake did not resume through start-up delay");

endmodule

// File: verification/rsw_pin_model.sv
// far-side model: external reset pin and the ten wake pins
// assumes callers enter its tasks right after a rising aclk edge
`timescale 1ns/1ps
module rsw_pin_model (
	input  wire logic aclk,
	output logic      ext_reset_n,
	output logic [7:0] port6_wake_pins,
	output logic [1:0] port7_wake_pins
);
	// released pins sit at the pull-up level
	initial begin
		ext_reset_n = 1'b1;
		port6_wake_pins = 8'hFF;
		port7_wake_pins = 2'h3;
	end
	// hold the reset pin low n cycles, then let the pull-up win
	task automatic press(input int n);
		ext_reset_n <= 1'b0;
		repeat (n) @(posedge aclk);
		ext_reset_n <= 1'b1;
	endtask
	// pins are inputs with pull-ups, so a 1 in p6 or p7 stands for a released pin
	task automatic pins(input logic [7:0] p6, input logic [1:0] p7);
		port6_wake_pins <= p6;
		port7_wake_pins <= p7;
	endtask
endmodule

// File: verification/test_reset_and_sleep_wakeup_ctrl.sv
// self-checking bench for the reset and sleep sequencer
// assumes a shortened start-up count; the register model is an int map
`timescale 1ns/1ps
module test_reset_and_sleep_wakeup_ctrl;
	localparam int SC = 16;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic bready = 1, rready = 1, power_on_det = 0, wdt_timeout = 0;
	logic watchdog_config_fuse = 0, enter_sleep_op = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, lr, port7_wake_pins;
	logic [7:0] port6_wake_pins, option_control_reg_q;
	logic [7:0] port5_dir_q, port6_dir_q, port7_dir_q;
	logic [9:0] program_counter_q;
	logic awready, wready, bvalid, arready, rvalid, ext_reset_n;
	logic core_reset_q, core_halt_q, osc_enable_q, wdt_enable_q;
	logic wdt_clear_q, prescaler_clear_q, c;
	int fails, n_checks, cyc, n, s;
	int m[int];
	int km[int] = '{0:'h78, 4:'hC0, 8:'hFF, 12:'hFF, 16:'h79, 20:9, 24:9};
	rsw_pin_model i_pins (.aclk, .ext_reset_n, .port6_wake_pins,
		.port7_wake_pins);
	rsw_seq #(.STARTUP_CYCLES(SC)) i_dut (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .power_on_det, .ext_reset_n, .wdt_timeout,
		.watchdog_config_fuse, .enter_sleep_op, .port6_wake_pins,
		.port7_wake_pins, .core_reset_q, .core_halt_q, .osc_enable_q,
		.wdt_enable_q, .wdt_clear_q, .prescaler_clear_q,
		.program_counter_q, .option_control_reg_q, .port5_dir_q,
		.port6_dir_q, .port7_dir_q);
	// 250 MHz clock
	always #2 aclk = ~aclk;
	// hang guard: the whole run needs well under 3000 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 5000) begin
			fails++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// write: offer both channels, drop each once taken, wait for B
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		lr = bresp;
		if (bresp === rsw_pkg::RESP_OKAY) m[a] = v[7:0];
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		lr = rresp;
	endtask
	// compare every modelled register under its checked-bit mask
	task automatic regs;
		for (int a = 0; a < 'h1C; a += 4) begin
			rd(a[7:0], d);
			chk("register", m[a] & km[a], d & km[a]);
		end
	endtask
	// model of what any reset does; power-on also clears more bits
	task automatic rst(input bit por);
		m[8] = por ? 'hBF : m[8] | 'hBF;
		m[12] = 'hFF;
		m[16] = 'h31;
		m[20] = por ? 0 : m[20] & ~9;
		m[24] = por ? 0 : m[24] & ~9;
		if (por) m[0] = 'h18;
		if (por) m[4] = 0;
	endtask
	// wait for the core to run again, counting the held cycles
	task automatic run;
		n = 0;
		while (core_halt_q !== 1'b0 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		// a hang cut off by the loop limit must not pass unnoticed
		chk("released", 0, core_halt_q);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		s = $urandom(32'h5f65);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rst(1);
		run();
		chk("startup", 1, n >= SC && n <= SC + 6);
		chk("pc", rsw_pkg::PC_RESET, program_counter_q);
		chk("option", 8'hBF, option_control_reg_q);
		chk("dirs", 24'hFFFFFF, {port5_dir_q, port6_dir_q, port7_dir_q});
		regs();
		wr(8'h18, $urandom & 'hFF);
		wr(8'h08, $urandom & 'hFF);
		regs();
		wr(rsw_pkg::OFS_SEQ, 0);
		chk("bresp", rsw_pkg::RESP_SLVERR, lr);
		rd(8'h40, d);
		chk("rresp", rsw_pkg::RESP_SLVERR, lr);
		// sleep 2: masked pin must not wake, enabled one must
		watchdog_config_fuse <= 1'b1;
		wr(8'h0C, 8'hFE);
		wr(8'h10, 8'h21);
		m[0] = 'h10;
		chk("osc", 0, osc_enable_q);
		i_pins.pins(8'hFD, 2'h3);
		repeat (8) @(posedge aclk);
		chk("osc", 0, osc_enable_q);
		chk("wdt on", 0, wdt_enable_q);
		i_pins.pins(8'hFC, 2'h3);
		run();
		chk("wake delay", 1, n >= SC && n <= SC + 6);
		chk("resume", 0, core_reset_q);
		chk("wdt on", 1, wdt_enable_q);
		m[16] = 'h31;
		regs();
		i_pins.pins(8'hFF, 2'h3);
		wr(8'h0C, 8'hFF);
		wr(8'h10, 8'h31);
		watchdog_config_fuse <= 1'b0;
		// reset pin: option bit 6 survives, flags unchanged
		wr(8'h08, 0);
		i_pins.press(6);
		chk("pin reset", 1, core_reset_q);
		rst(0);
		run();
		chk("pc", rsw_pkg::PC_RESET, program_counter_q);
		chk("option", m[8], option_control_reg_q);
		regs();
		// sleep 1, then a watchdog time-out wakes through reset
		enter_sleep_op <= 1'b1;
		@(posedge aclk);
		enter_sleep_op <= 1'b0;
		c = 0;
		repeat (3) @(posedge aclk) c |= wdt_clear_q & prescaler_clear_q;
		chk("wdt clear", 1, c);
		chk("halt", 1, core_halt_q);
		rd(rsw_pkg::OFS_SEQ, d);
		chk("state", 2, d & 7);
		regs();
		wdt_timeout <= 1'b1;
		@(posedge aclk);
		wdt_timeout <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("wdt reset", 1, core_reset_q);
		m[0] = 0;
		rst(0);
		run();
		regs();
		// power-on pulse: status bits 6-5 and bank bits 7-6 go to zero
		wr(8'h00, 'h60);
		wr(8'h04, 'hFF);
		power_on_det <= 1'b1;
		@(posedge aclk);
		power_on_det <= 1'b0;
		rst(1);
		run();
		regs();
		finish_test();
	end
endmodule
